// >>> dv/uhp_modem_model.sv
// modem model driving the far-end control inputs of one channel
`timescale 1ns/10ps
module uhp_modem_model (
	// clock
	input wire logic clock_in,
	// commands from the bench
	input wire logic ready_in,
	input wire logic accept_in,
	input wire logic ring_in,
	// modem pins, idle high
	output logic dsr_n_out,
	output logic cts_n_out,
	output logic ri_n_out
);
	// pins move just after an edge, so the design sees clean steps
	always_ff @(posedge clock_in) begin
		dsr_n_out <= !ready_in;
		cts_n_out <= !accept_in;
		ri_n_out <= !ring_in;
	end
endmodule

// >>> dv/uhp_top_tb_top.sv
// self-checking bench for the host port and modem pin block
`timescale 1ns/10ps
`include "uhp_defines.svh"
module uhp_top_tb_top;
	import uhp_pkg::*;
	logic clock_in = 1'h0;
	logic rstn_in = 1'h0;
	logic cs_n = 1'h1;
	logic rd_n = 1'h1;
	logic wr_n = 1'h1;
	logic [2:0] a = 3'h0;
	logic [7:0] d = 8'h00;
	logic [2:0] ev = 3'h0;
	logic busy = 1'h0;
	logic acc = 1'h0;
	logic rdy = 1'h0;
	logic ring = 1'h0;
	logic cts_n, dsr_n, ri_n, bus_oe, dtr_n, usr_n, irq, irq_oe, allow, sen;
	logic [7:0] bus_d;
	logic [7:0] txd;
	logic [7:0] lctl;
	uhp_pins_s pins;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	assign pins = {cs_n, rd_n, wr_n, a, d, cts_n, dsr_n, ri_n};

	// ----------------------------------------
	// clock, partner and design
	// ----------------------------------------
	initial begin
		forever #4 clock_in = ~clock_in;
	end
	uhp_modem_model modem (.clock_in(clock_in), .ready_in(rdy),
		.accept_in(acc), .ring_in(ring), .dsr_n_out(dsr_n),
		.cts_n_out(cts_n), .ri_n_out(ri_n));
	uhp_top uut (.clock_in(clock_in), .rstn_in(rstn_in), .pins_in(pins),
		.bus_data_out(bus_d), .bus_data_oe_out(bus_oe),
		.dtr_n_out(dtr_n), .user_out_n_out(usr_n), .chan_irq_out(irq),
		.chan_irq_oe_out(irq_oe), .rx_err_in(ev[0]),
		.rx_avail_in(ev[1]), .rx_data_in(8'h6B), .tx_done_in(ev[2]),
		.tx_busy_in(busy), .tx_data_out(txd), .tx_load_out(),
		.tx_allow_out(allow), .serial_en_out(sen), .line_ctrl_out(lctl));

	// ----------------------------------------
	// bus tasks and checks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	// strobes held long enough for the two-flop input sync
	task automatic wr(input logic [2:0] ad, input logic [7:0] v, logic sel);
		@(posedge clock_in);
		cs_n <= !sel;
		wr_n <= 1'h0;
		a <= ad;
		d <= v;
		tick(4);
		wr_n <= 1'h1;
		tick(4);
		cs_n <= 1'h1;
		tick(4);
	endtask
	// bus input shows the inverse, so a leak of the pin is caught
	task automatic rd(input logic [2:0] ad, input logic [7:0] e);
		@(posedge clock_in);
		cs_n <= 1'h0;
		rd_n <= 1'h0;
		a <= ad;
		d <= ~e;
		tick(5);
		@(negedge clock_in);
		chk("bus_oe", bus_oe, 8'h01);
		chk("bus_data", bus_d, e);
		@(posedge clock_in);
		rd_n <= 1'h1;
		cs_n <= 1'h1;
		tick(4);
		@(negedge clock_in);
		chk("bus_oe_idle", bus_oe, 8'h00);
	endtask
	task automatic end_of_test;
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		tick(6);
		rstn_in <= 1'h1;
		tick(3);
		@(negedge clock_in);
		chk("dtr_n", dtr_n, 8'h01);
		chk("user_n", usr_n, 8'h01);
		chk("irq_oe", irq_oe, 8'h00);
		chk("bus_oe", bus_oe, 8'h00);
		chk("serial_en", sen, 8'h01);
		wr(`UHP_OFS_SPR, 8'hA5, 1'h1);
		wr(`UHP_OFS_SPR, 8'h5A, 1'h0);
		rd(`UHP_OFS_SPR, 8'hA5);
		rd(`UHP_OFS_DATA, 8'h6B);
		wr(`UHP_OFS_DATA, 8'h3C, 1'h1);
		chk("tx_data", txd, 8'h3C);
		wr(`UHP_OFS_MCR, 8'h09, 1'h1);
		rd(`UHP_OFS_MCR, 8'h09);
		chk("dtr_n", dtr_n, 8'h00);
		chk("user_n", usr_n, 8'h00);
		chk("irq_oe", irq_oe, 8'h01);
		// each core event alone, unmasked one at a time
		for (int i = 0; i < 3; i++) begin
			wr(`UHP_OFS_IER, 8'(1 << i), 1'h1);
			ev <= 3'(1 << i);
			@(posedge clock_in);
			ev <= 3'h0;
			tick(3);
			chk("irq", irq, 8'h01);
			rd(`UHP_OFS_ISR, 8'(1 << i));
			chk("irq_clr", irq, 8'h00);
		end
		wr(`UHP_OFS_IER, 8'h08, 1'h1);
		acc <= 1'h1;
		rdy <= 1'h1;
		tick(6);
		chk("irq_modem", irq, 8'h01);
		rd(`UHP_OFS_MSR, 8'h33);
		rd(`UHP_OFS_ISR, 8'h08);
		rd(`UHP_OFS_MSR, 8'h30);
		ring <= 1'h1;
		tick(6);
		chk("irq_ring_low", irq, 8'h00);
		rd(`UHP_OFS_MSR, 8'h70);
		ring <= 1'h0;
		tick(6);
		chk("irq_ring", irq, 8'h01);
		rd(`UHP_OFS_MSR, 8'h34);
		wr(`UHP_OFS_MCR, 8'h01, 1'h1);
		chk("irq_gated", irq, 8'h00);
		chk("irq_oe", irq_oe, 8'h00);
		chk("user_n", usr_n, 8'h01);
		// feature register: auto flow and rs-485 steering
		wr(`UHP_OFS_LCR, `UHP_EFR_KEY, 1'h1);
		chk("line_ctrl", lctl, `UHP_EFR_KEY);
		wr(`UHP_OFS_ISR, 8'hA0, 1'h1);
		wr(`UHP_OFS_LCR, 8'h00, 1'h1);
		chk("allow_cts", allow, 8'h01);
		acc <= 1'h0;
		busy <= 1'h1;
		tick(6);
		@(negedge clock_in);
		chk("allow_stop", allow, 8'h00);
		chk("dtr_485_on", dtr_n, 8'h00);
		@(posedge clock_in);
		busy <= 1'h0;
		tick(3);
		@(negedge clock_in);
		chk("dtr_485_off", dtr_n, 8'h01);
		// second reset in mid-run
		@(posedge clock_in);
		rstn_in <= 1'h0;
		tick(3);
		@(negedge clock_in);
		chk("serial_en", sen, 8'h00);
		chk("allow_rst", allow, 8'h00);
		@(posedge clock_in);
		rstn_in <= 1'h1;
		tick(3);
		@(negedge clock_in);
		chk("allow_efr", allow, 8'h01);
		chk("dtr_n", dtr_n, 8'h01);
		end_of_test();
	end
endmodule

// >>> rtl/uhp_defines.svh
// constants of the host port and modem pin block
//
// Notes on behaviour
// RL1 - bus transfer only while select is low
// RL2 - read strobe low drives addressed register out
// RL3 - write strobe captures bus into addressed register
// RL4 - eight bit three-state bus, bit zero lsb
// RL5 - clear-to-send level seen in status bit 4
// RL6 - clear-to-send gates transfer only if enabled
// RL7 - control bit 0 drives terminal-ready low
// RL8 - terminal-ready pin steers rs-485 driver
// RL9 - irq needs bit 3, enable, pending
// RL10 - four interrupt sources including modem change
// RL11 - irq pin high impedance after reset
// RL12 - bit 3 drives irq, user pin low
// RL13 - user output pin high after reset
// RL14 - reset clears registers and outputs
// RL15 - serial lines disabled during reset
// RL16 - ring rising edge raises modem interrupt
// RL17 - modem pulls data-set-ready low when ready
// RL18 - three address bits choose the register
// RL19 - bus released unless selected and reading
`ifndef UHP_DEFINES_SVH
`define UHP_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define UHP_OFS_DATA 3'h0
`define UHP_OFS_IER 3'h1
`define UHP_OFS_ISR 3'h2
`define UHP_OFS_LCR 3'h3
`define UHP_OFS_MCR 3'h4
`define UHP_OFS_LSR 3'h5
`define UHP_OFS_MSR 3'h6
`define UHP_OFS_SPR 3'h7
// feature register sits at the status offset behind this key
`define UHP_EFR_KEY 8'hBF

// ----------------------------------------
// field positions
// ----------------------------------------
`define UHP_MCR_DTR 0
`define UHP_MCR_IRQ_EN 3
`define UHP_EFR_RS485 5
`define UHP_EFR_AUTO_CTS 7
`define UHP_MSR_CTS 4
`define UHP_MSR_DSR 5
`define UHP_MSR_RI 6
`define UHP_MSR_DCTS 0
`define UHP_MSR_DDSR 1
`define UHP_MSR_TERI 2
`define UHP_SRC_RXERR 0
`define UHP_SRC_RXAV 1
`define UHP_SRC_THRE 2
`define UHP_SRC_MODEM 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define UHP_RST_BYTE 8'h00
`define UHP_RST_SRC 4'h0
`define UHP_RST_PINS 17'h1_FFFF

`endif

// >>> rtl/uhp_pkg.sv
// types shared by the host port block
package uhp_pkg;
	// raw host and modem pins, all active low except addr and data
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [2:0] addr;
		logic [7:0] data;
		logic cts_n;
		logic dsr_n;
		logic ri_n;
	} uhp_pins_s;
	// interrupt sources, one bit each
	typedef logic [3:0] uhp_src_t;
	// host bus phase
	typedef enum logic [2:0] {
		UHP_IDLE = 3'b001,
		UHP_READ = 3'b010,
		UHP_WRITE = 3'b100
	} uhp_phase_e;
endpackage

// >>> rtl/uhp_top.sv
// one channel: host bus slave, modem pins and interrupt pin
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
`include "uhp_defines.svh"

module uhp_top (
	// clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// host and modem pins, asynchronous
	input wire uhp_pkg::uhp_pins_s pins_in,
	// data bus drive
	output logic [7:0] bus_data_out,
	output logic bus_data_oe_out,
	// modem and user pins
	output logic dtr_n_out,
	output logic user_out_n_out,
	// interrupt pin drive
	output logic chan_irq_out,
	output logic chan_irq_oe_out,
	// serial core side, same clock
	input wire logic rx_err_in,
	input wire logic rx_avail_in,
	input wire logic [7:0] rx_data_in,
	input wire logic tx_done_in,
	input wire logic tx_busy_in,
	output logic [7:0] tx_data_out,
	output logic tx_load_out,
	output logic tx_allow_out,
	output logic serial_en_out,
	output logic [7:0] line_ctrl_out
);
	import uhp_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	uhp_pins_s s1_q;
	uhp_pins_s s2_q;
	uhp_pins_s s3_q;

	// two stages, then one more for edge detection
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			s1_q <= `UHP_RST_PINS;
			s2_q <= `UHP_RST_PINS;
			s3_q <= `UHP_RST_PINS;
		end else begin
			s1_q <= pins_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// ----------------------------------------
	// strobe decode
	// ----------------------------------------
	logic rd_act;
	logic rd_start;
	logic wr_end;
	uhp_phase_e phase_q;

	// select must be low for any transfer [RL1]
	assign rd_act = !s2_q.cs_n && !s2_q.rd_n;
	assign rd_start = rd_act && (s3_q.rd_n || s3_q.cs_n);
	// capture at strobe release, data held by host there [RL3]
	// the phase guard drops a release seen without a tracked write
	assign wr_end = (phase_q == UHP_WRITE) && !s3_q.cs_n &&
		!s3_q.wr_n && s2_q.wr_n;

	// bus phase tracker
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			phase_q <= UHP_IDLE;
		end else begin
			case (phase_q)
				UHP_IDLE: begin
					if (rd_act)
						phase_q <= UHP_READ;
					else if (!s2_q.cs_n && !s2_q.wr_n)
						phase_q <= UHP_WRITE;
				end
				UHP_READ: begin
					if (!rd_act)
						phase_q <= UHP_IDLE;
				end
				UHP_WRITE: begin
					if (s2_q.wr_n || s2_q.cs_n)
						phase_q <= UHP_IDLE;
				end
				default: phase_q <= UHP_IDLE;
			endcase
		end
	end

	// true when a write ends at the given offset
	function automatic logic wr_at(input logic [2:0] ofs);
		wr_at = wr_end && (s3_q.addr == ofs);
	endfunction

	// true when a read starts at the given offset
	function automatic logic rd_at(input logic [2:0] ofs);
		rd_at = rd_start && (s2_q.addr == ofs);
	endfunction

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [7:0] ier_q;
	logic [7:0] lcr_q;
	logic [7:0] mcr_q;
	logic [7:0] efr_q;
	logic [7:0] spr_q;
	logic efr_sel;

	// feature register hidden behind the line control key
	assign efr_sel = (lcr_q == `UHP_EFR_KEY);

	// software writes, address picks the target [RL3] [RL18]
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			ier_q <= `UHP_RST_BYTE;
			lcr_q <= `UHP_RST_BYTE;
			mcr_q <= `UHP_RST_BYTE;
			efr_q <= `UHP_RST_BYTE;
			spr_q <= `UHP_RST_BYTE;
		end else begin
			if (wr_at(`UHP_OFS_IER))
				ier_q <= s3_q.data;
			if (wr_at(`UHP_OFS_LCR))
				lcr_q <= s3_q.data;
			if (wr_at(`UHP_OFS_MCR))
				mcr_q <= s3_q.data;
			if (wr_at(`UHP_OFS_ISR) && efr_sel)
				efr_q <= s3_q.data;
			if (wr_at(`UHP_OFS_SPR))
				spr_q <= s3_q.data;
		end
	end

	// transmit holding write hands the byte to the serial core
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			tx_data_out <= `UHP_RST_BYTE;
			tx_load_out <= 1'b0;
		end else begin
			tx_load_out <= wr_at(`UHP_OFS_DATA);
			if (wr_at(`UHP_OFS_DATA))
				tx_data_out <= s3_q.data; // bit 0 goes first [RL4]
		end
	end

	// ----------------------------------------
	// modem status
	// ----------------------------------------
	logic [2:0] delta_q;
	logic [2:0] delta_set;
	logic msr_rd;

	assign msr_rd = rd_at(`UHP_OFS_MSR);
	assign delta_set[`UHP_MSR_DCTS] = s2_q.cts_n ^ s3_q.cts_n;
	assign delta_set[`UHP_MSR_DDSR] = s2_q.dsr_n ^ s3_q.dsr_n;
	// only the low-to-high ring edge counts [RL16]
	assign delta_set[`UHP_MSR_TERI] = s2_q.ri_n && !s3_q.ri_n;

	// deltas are sticky; a read clears, a new edge wins
	always_ff @(posedge clock_in) begin
		if (!rstn_in)
			delta_q <= 3'h0;
		else
			delta_q <= (msr_rd ? 3'h0 : delta_q) | delta_set;
	end

	// ----------------------------------------
	// interrupt sources
	// ----------------------------------------
	uhp_src_t src_q;
	uhp_src_t src_set;
	logic isr_rd;

	assign isr_rd = rd_at(`UHP_OFS_ISR) && !efr_sel;
	// four sources, modem change included [RL10] [RL16]
	assign src_set[`UHP_SRC_RXERR] = rx_err_in;
	assign src_set[`UHP_SRC_RXAV] = rx_avail_in;
	assign src_set[`UHP_SRC_THRE] = tx_done_in;
	assign src_set[`UHP_SRC_MODEM] = |delta_set;

	// sticky status, cleared by its read, set wins over clear
	always_ff @(posedge clock_in) begin
		if (!rstn_in)
			src_q <= `UHP_RST_SRC;
		else
			src_q <= (isr_rd ? `UHP_RST_SRC : src_q) | src_set;
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [7:0] rd_mux;
	logic [7:0] msr_val;
	logic [7:0] lsr_val;

	// levels shown true-high, so a low pin reads as 1 [RL5]
	always_comb begin
		msr_val = {1'b0, !s2_q.ri_n, !s2_q.dsr_n, !s2_q.cts_n,
			1'b0, delta_q};
	end

	// line status: holding empty, receive error and data flags only
	always_comb begin
		lsr_val = {5'h00, src_q[`UHP_SRC_THRE], src_q[`UHP_SRC_RXERR],
			src_q[`UHP_SRC_RXAV]};
	end

	// register picked by the three address bits [RL2] [RL18]
	always_comb begin
		case (s2_q.addr)
			`UHP_OFS_DATA: rd_mux = rx_data_in;
			`UHP_OFS_IER: rd_mux = ier_q;
			`UHP_OFS_ISR: rd_mux = efr_sel ? efr_q : {4'h0, src_q};
			`UHP_OFS_LCR: rd_mux = lcr_q;
			`UHP_OFS_MCR: rd_mux = mcr_q;
			`UHP_OFS_LSR: rd_mux = lsr_val;
			`UHP_OFS_MSR: rd_mux = msr_val;
			`UHP_OFS_SPR: rd_mux = spr_q;
			default: rd_mux = `UHP_RST_BYTE;
		endcase
	end

	// data latched at strobe start so a clearing read shows its value
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			bus_data_out <= `UHP_RST_BYTE;
			bus_data_oe_out <= 1'b0;
		end else begin
			bus_data_oe_out <= rd_act; // released otherwise [RL19] [RL4]
			if (rd_start)
				bus_data_out <= rd_mux; // [RL2]
		end
	end

	// ----------------------------------------
	// modem, user and serial pins
	// ----------------------------------------
	// rs-485 mode turns terminal-ready into driver enable [RL8]
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			dtr_n_out <= 1'b1; // [RL14]
		end else if (efr_q[`UHP_EFR_RS485]) begin
			dtr_n_out <= !tx_busy_in; // [RL8]
		end else begin
			dtr_n_out <= !mcr_q[`UHP_MCR_DTR]; // [RL7]
		end
	end

	// flow gate only counts when auto clear-to-send is on [RL6]
	always_ff @(posedge clock_in) begin
		if (!rstn_in)
			tx_allow_out <= 1'b0;
		else
			tx_allow_out <= !efr_q[`UHP_EFR_AUTO_CTS] || !s2_q.cts_n;
	end

	// serial lines held off while reset is low [RL15]
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			serial_en_out <= 1'b0;
			line_ctrl_out <= `UHP_RST_BYTE;
		end else begin
			serial_en_out <= 1'b1;
			line_ctrl_out <= lcr_q;
		end
	end

	// ----------------------------------------
	// interrupt pin
	// ----------------------------------------
	logic irq_pend;

	// masked sources; the pin itself waits for the enable bit
	assign irq_pend = |(src_q & ier_q[3:0]);

	// enable bit drives the pin, otherwise released [RL9] [RL12]
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			chan_irq_out <= 1'b0;
			chan_irq_oe_out <= 1'b0; // floats out of reset [RL11]
			user_out_n_out <= 1'b1; // [RL13]
		end else begin
			chan_irq_oe_out <= mcr_q[`UHP_MCR_IRQ_EN]; // [RL12]
			user_out_n_out <= !mcr_q[`UHP_MCR_IRQ_EN]; // [RL12]
			chan_irq_out <= mcr_q[`UHP_MCR_IRQ_EN] && irq_pend; // [RL9]
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	chk_irq_needs_all: assert property ( // [RL9]
		chan_irq_out |-> $past(mcr_q[3]) && $past(irq_pend))
		else $error("irq high without enable or pending");

	chk_irq_pin_float: assert property ( // [RL12]
		!chan_irq_oe_out |-> user_out_n_out && !chan_irq_out)
		else $error("irq released but user pin low");

	chk_user_pin_pair: assert property ( // [RL12]
		user_out_n_out != chan_irq_oe_out)
		else $error("user pin and irq drive disagree");

	chk_bus_release: assert property ( // [RL19]
		!rd_act |=> !bus_data_oe_out)
		else $error("bus driven without read");

	chk_read_drive: assert property ( // [RL2]
		rd_start |=> bus_data_oe_out && bus_data_out == $past(rd_mux))
		else $error("read data not presented");

	chk_dtr_follow: assert property ( // [RL7]
		!efr_q[5] && $stable(efr_q) |=> dtr_n_out == !$past(mcr_q[0]))
		else $error("terminal ready does not follow control");

	chk_ring_edge: assert property ( // [RL16]
		s2_q.ri_n && !s3_q.ri_n |=> src_q[3] && delta_q[2])
		else $error("ring edge lost");

	chk_set_wins: assert property ( // [RL10]
		isr_rd && rx_avail_in |=> src_q[1])
		else $error("event lost on clearing read");

	chk_cts_gate: assert property ( // [RL6]
		!efr_q[7] |=> tx_allow_out)
		else $error("clear-to-send gates without auto mode");

	chk_write_take: assert property ( // [RL3]
		wr_at(`UHP_OFS_SPR) |=> spr_q == $past(s3_q.data))
		else $error("write not captured");

	chk_select_gate: assert property ( // [RL1]
		s2_q.cs_n |=> !bus_data_oe_out ##1 !tx_load_out)
		else $error("bus active without select");

	chk_serial_on: assert property ( // [RL15]
		$rose(rstn_in) |-> !serial_en_out ##1 serial_en_out)
		else $error("serial enable timing wrong");

	chk_irq_reset_float: assert property ( // [RL11] [RL13]
		$rose(rstn_in) |-> !chan_irq_oe_out && user_out_n_out)
		else $error("irq pin or user pin wrong after reset");

	chk_irq_mask_low: assert property ( // [RL9]
		mcr_q[`UHP_MCR_IRQ_EN] && !irq_pend |=> !chan_irq_out)
		else $error("irq high with nothing unmasked pending");

	chk_dtr_485: assert property ( // [RL8]
		efr_q[`UHP_EFR_RS485] |=> dtr_n_out == !$past(tx_busy_in))
		else $error("terminal ready does not steer driver");

	chk_status_clear: assert property ( // [RL10]
		isr_rd && src_set == `UHP_RST_SRC |=> src_q == `UHP_RST_SRC)
		else $error("status read did not clear");

	chk_tx_hand: assert property ( // [RL4]
		wr_at(`UHP_OFS_DATA) |=> tx_load_out &&
			tx_data_out == $past(s3_q.data))
		else $error("transmit byte not handed over");

	chk_msr_levels: assert property ( // [RL5] [RL16]
		msr_rd |=> bus_data_out[`UHP_MSR_CTS] == !$past(s2_q.cts_n) &&
			bus_data_out[`UHP_MSR_RI] == !$past(s2_q.ri_n))
		else $error("modem levels misreported");
endmodule
